// ===== hdl/mmt_membership_table.sv
// Purpose: multicast membership table with indirect command access and snooping
// Assumes: frame header fields arrive parsed, on the same clock, as one pulse
// Notes: one table port shared by software commands and the snoop engine
`default_nettype none

module mmt_membership_table
   import mmt_pkg::*;
#(
   parameter int ENTRIES = ENTRY_COUNT,
   parameter int PORTS = PORT_COUNT
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [WORD_W-1:0] regWriteData,
   output logic [WORD_W-1:0] regReadData,
   output logic regReadValid,
   input wire logic snoopEnable,
   input wire logic [PORTS-1:0] staticPortMap,
   input wire logic frameValid,
   input wire mmt_frame_type frameHeader,
   output logic frameReady,
   output logic classValid,
   output mmt_class_type classResult,
   output logic fwdValid,
   output logic [PORTS-1:0] fwdPortMap,
   output logic tableFull
);
   // entry layout has no room for other sizes
   if (ENTRIES != ENTRY_COUNT || PORTS != PORT_COUNT) begin : g_bad_size
      $error("mmt_membership_table: entry layout fixed at 32 x 6 ports");
   end

   typedef enum {
      ST_IDLE,
      ST_CMD_READ,
      ST_CMD_DONE,
      ST_SCAN_READ,
      ST_SCAN_CHECK,
      ST_UPDATE
   } mmt_state_type;

   mmt_state_type state;
   mmt_state_type next_state;

   logic [WORD_W-1:0] ctrlWord [6];
   logic [WORD_W-1:0] statWord [4];
   logic [INDEX_W-1:0] statIndex;
   logic busy;
   logic [2:0] result;

   // register port decode
   wire ctrlHit = regAddr >= REG_CTRL0 && regAddr <= REG_CTRL5;
   wire statHit = regAddr >= REG_STAT0 && regAddr <= REG_STAT5;
   wire [2:0] ctrlSel = 3'(regAddr - REG_CTRL0);
   wire [2:0] statSel = 3'(regAddr - REG_STAT0);
   // operands are frozen while a command runs
   wire ctrlWrite = regWrite && ctrlHit && !busy;
   wire cmdStart = ctrlWrite && ctrlSel == 3'h5;

   wire [CMD_W-1:0] cmdCode = ctrlWord[5][CMD_LSB +: CMD_W];
   wire [INDEX_W-1:0] cmdIndex = ctrlWord[4][INDEX_W-1:0];
   wire [ENTRY_W-1:0] cmdData = {ctrlWord[3][HIGH_W-1:0], ctrlWord[2],
                                 ctrlWord[1], ctrlWord[0]};
   wire cmdIsWrite = cmdCode == CMD_TABLE_WRITE;
   wire cmdIsRead = cmdCode == CMD_TABLE_READ;

   // frame classification
   wire [31:0] dip = frameHeader.dstIp;
   wire [31:0] group_destination = frameHeader.groupAddr;
   wire isIgmp = frameHeader.ethType == ETH_TYPE_IPV4
                 && frameHeader.ipVersion == IP_VER4
                 && frameHeader.ipProto == PROTO_IGMP;
   wire gdaMulticast = group_destination >= CLASS_D_LO && group_destination <= CLASS_D_HI;
   wire gdaReserved = group_destination >= RESERVED_LO && group_destination <= RESERVED_HI;
   wire dipMulticast = dip >= CLASS_D_LO && dip <= CLASS_D_HI;
   wire genQuery = isIgmp && dip == ALL_HOSTS_IP
                   && frameHeader.msgType == MSG_QUERY
                   && group_destination == 32'h00000000;
   wire isReport = frameHeader.msgType == MSG_REPORT_V1
                   || frameHeader.msgType == MSG_REPORT_V2;
   // reserved groups never gain members, so joins are refused for them
   wire joinMsg = isIgmp && isReport && gdaMulticast && !gdaReserved;
   wire leaveMsg = isIgmp && frameHeader.msgType == MSG_LEAVE
                   && gdaMulticast && !gdaReserved;
   wire portValid = frameHeader.rxPort < PORT_ID_W'(PORTS);
   wire frameTake = frameValid && frameReady;
   // the snoop engine touches the table only with snooping switched on
   wire snoopStart = frameTake && snoopEnable && portValid
                     && (joinMsg || leaveMsg);

   wire [GROUP_W-1:0] frameGroup = group_destination[GROUP_W-1:0];
   wire [47:0] frameMac = {MAC_OUI, 1'b0, group_destination[GROUP_W-1:0]};

   // snoop job state
   logic jobJoin;
   logic [GROUP_W-1:0] jobGroup;
   logic [PORTS-1:0] jobPortBit;
   logic [INDEX_W-1:0] scanIndex;
   logic hitFound;
   logic [INDEX_W-1:0] hitIndex;
   mmt_entry_type hitEntry;
   logic freeFound;
   logic [INDEX_W-1:0] freeIndex;

   // table port
   logic memWrite;
   logic [INDEX_W-1:0] memAddr;
   logic [ENTRY_W-1:0] memWriteData;
   logic [ENTRY_W-1:0] memReadData;
   mmt_entry_type readEntry;
   assign readEntry = mmt_entry_type'(memReadData);

   mmt_table_mem #(
      .DEPTH(ENTRY_COUNT),
      .WIDTH(ENTRY_W)
   ) u_mem (
      .clk(clk),
      .writeEn(memWrite),
      .addr(memAddr),
      .writeData(memWriteData),
      .readData(memReadData)
   );

   wire scanLast = scanIndex == INDEX_W'(ENTRIES - 1);
   // bad entries are skipped both as matches and as free slots
   wire entryUsable = !readEntry.bad;
   wire entryMatch = entryUsable && readEntry.occupied
                     && readEntry.groupIdentifier == jobGroup;
   wire entryFree = entryUsable && !readEntry.occupied;

   wire [PORTS-1:0] joinMap = hitEntry.portMap | jobPortBit;
   wire [PORTS-1:0] leaveMap = hitEntry.portMap & ~jobPortBit;

   mmt_entry_type updEntry;
   mmt_entry_type newEntry;
   always_comb begin
      updEntry = hitEntry;
      updEntry.reserved = '0;
      updEntry.portMap = jobJoin ? joinMap : leaveMap;
      // the last member leaving frees the slot
      updEntry.occupied = |updEntry.portMap;
      newEntry = '0;
      newEntry.occupied = 1'b1;
      newEntry.portMap = jobPortBit;
      newEntry.groupIdentifier = jobGroup;
   end

   wire updWrite = hitFound || (jobJoin && freeFound);
   wire noRoom = jobJoin && !hitFound && !freeFound;

   always_comb begin
      next_state = state;
      memWrite = 1'b0;
      memAddr = scanIndex;
      memWriteData = cmdData;
      unique case (state)
         ST_IDLE: begin
            // software commands win over waiting snoop frames
            if (busy) begin
               memAddr = cmdIndex;
               memWrite = cmdIsWrite;
               next_state = cmdIsRead ? ST_CMD_READ : ST_CMD_DONE;
            end else if (snoopStart) begin
               next_state = ST_SCAN_READ;
            end
         end
         ST_CMD_READ: begin
            memAddr = cmdIndex;
            next_state = ST_CMD_DONE;
         end
         ST_CMD_DONE: begin
            next_state = ST_IDLE;
         end
         ST_SCAN_READ: begin
            next_state = ST_SCAN_CHECK;
         end
         ST_SCAN_CHECK: begin
            next_state = scanLast ? ST_UPDATE : ST_SCAN_READ;
         end
         ST_UPDATE: begin
            memWrite = updWrite;
            memAddr = hitFound ? hitIndex : freeIndex;
            memWriteData = hitFound ? updEntry : newEntry;
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // control words
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 6; i++) begin
            ctrlWord[i] <= '0;
         end
      end else if (ctrlWrite) begin
         ctrlWord[ctrlSel] <= regWriteData;
      end
   end

   // busy and result; busy cannot be set and cleared in one cycle
   wire cmdFinish = state == ST_CMD_DONE;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy <= 1'b0;
         result <= RES_OK;
      end else if (cmdStart) begin
         busy <= 1'b1;
      end else if (cmdFinish) begin
         busy <= 1'b0;
         result <= (cmdIsWrite || cmdIsRead) ? RES_OK : RES_BAD_CMD;
      end
   end

   // status words load on read completion
   wire readLoad = cmdFinish && cmdIsRead;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            statWord[i] <= '0;
         end
         statIndex <= '0;
      end else if (readLoad) begin
         statWord[3] <= WORD_W'(memReadData[ENTRY_W-1 -: HIGH_W]);
         statWord[2] <= memReadData[3*WORD_W-1 -: WORD_W];
         statWord[1] <= memReadData[2*WORD_W-1 -: WORD_W];
         statWord[0] <= memReadData[WORD_W-1:0];
         statIndex <= cmdIndex;
      end
   end

   // register read mux; unmapped indices read zero
   wire [WORD_W-1:0] stat5 = {busy, result, 12'h000};
   wire [WORD_W-1:0] stat4 = WORD_W'(statIndex);
   wire [WORD_W-1:0] statMux = statSel == 3'h5 ? stat5
                              : statSel == 3'h4 ? stat4
                              : statWord[statSel[1:0]];
   wire [WORD_W-1:0] readMux = ctrlHit ? ctrlWord[ctrlSel]
                              : statHit ? statMux : '0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regReadData <= '0;
         regReadValid <= 1'b0;
      end else begin
         regReadData <= regRead ? readMux : '0;
         regReadValid <= regRead;
      end
   end

   // snoop job capture and scan bookkeeping
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         jobJoin <= 1'b0;
         jobGroup <= '0;
         jobPortBit <= '0;
         scanIndex <= '0;
         hitFound <= 1'b0;
         hitIndex <= '0;
         hitEntry <= '0;
         freeFound <= 1'b0;
         freeIndex <= '0;
      end else if (state == ST_IDLE && !busy && snoopStart) begin
         jobJoin <= joinMsg;
         jobGroup <= frameGroup;
         jobPortBit <= PORTS'(1) << frameHeader.rxPort;
         scanIndex <= '0;
         hitFound <= 1'b0;
         freeFound <= 1'b0;
      end else if (state == ST_SCAN_CHECK) begin
         if (entryMatch && !hitFound) begin
            hitFound <= 1'b1;
            hitIndex <= scanIndex;
            hitEntry <= readEntry;
         end
         if (entryFree && !freeFound) begin
            freeFound <= 1'b1;
            freeIndex <= scanIndex;
         end
         if (!scanLast) begin
            scanIndex <= scanIndex + 1'b1;
         end
      end
   end

   // frames are taken only while the engine is idle and no command waits
   wire next_frameReady = next_state == ST_IDLE
                          && !(cmdStart || (busy && !cmdFinish));
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frameReady <= 1'b0;
      end else begin
         frameReady <= next_frameReady;
      end
   end

   // classification of every accepted frame
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         classValid <= 1'b0;
         classResult <= '0;
      end else begin
         classValid <= frameTake;
         if (frameTake) begin
            classResult.isMulticast <= dipMulticast;
            classResult.isReserved <= gdaReserved;
            classResult.isGeneralQuery <= genQuery;
            classResult.isJoin <= joinMsg;
            classResult.isLeave <= leaveMsg;
            classResult.groupMac <= frameMac;
         end
      end
   end

   // forwarding map after each table update
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fwdValid <= 1'b0;
         fwdPortMap <= '0;
         tableFull <= 1'b0;
      end else begin
         fwdValid <= state == ST_UPDATE;
         if (state == ST_UPDATE) begin
            if (noRoom) begin
               fwdPortMap <= staticPortMap;
            end else if (hitFound) begin
               fwdPortMap <= updEntry.portMap;
            end else if (jobJoin) begin
               fwdPortMap <= jobPortBit;
            end else begin
               fwdPortMap <= '0;
            end
            tableFull <= noRoom;
         end
      end
   end
endmodule // mmt_membership_table

`default_nettype wire

// ===== hdl/mmt_table_mem.sv
// How it works
// - entry bit 57 flags self-test failure
// - entry bit 56 marks entry occupied
// - bits 28:23 are per-port membership map
// - bits 22:0 hold the group identifier
// - command from ctrl5[6:4], index ctrl4[4:0]
// - write data is ctrl3[9:0],ctrl2,ctrl1,ctrl0
// - command 100 writes the selected entry
// - command 101 reads entry into status words
// - status5 bit15 busy, bits14:12 result
// - status4 index; status3..0 carry entry, high first
// - report sets receiving port in group map
// - leave clears sending port from group map
// - class D destinations are multicast groups
// - group MAC is 01-00-5e plus low 23 bits
// - 224.0.0.1 to 224.0.0.255 reserved, no membership
// - general query recognised by all header fields
// - snooping updates only while snoop enable set
// - 32 entries; when full use static map
//
// Purpose: package and entry memory of the multicast membership table
// Assumes: single clock, synchronous write, registered read
// Notes: memory holds no reset; entries are defined by software or snooping
`default_nettype none

package mmt_pkg;
   localparam int ENTRY_COUNT = 32;
   localparam int INDEX_W = 5;
   localparam int PORT_COUNT = 6;
   localparam int GROUP_W = 23;
   localparam int RSVD_W = 27;
   localparam int ENTRY_W = 58;
   localparam int WORD_W = 16;
   localparam int HIGH_W = 10;
   localparam int REG_ADDR_W = 9;
   localparam int PORT_ID_W = 3;

   typedef struct packed {
      logic bad;
      logic occupied;
      logic [RSVD_W-1:0] reserved;
      logic [PORT_COUNT-1:0] portMap;
      logic [GROUP_W-1:0] groupIdentifier;
   } mmt_entry_type;

   localparam logic [REG_ADDR_W-1:0] REG_CTRL0 = 9'h11A;
   localparam logic [REG_ADDR_W-1:0] REG_CTRL5 = 9'h11F;
   localparam logic [REG_ADDR_W-1:0] REG_STAT0 = 9'h120;
   localparam logic [REG_ADDR_W-1:0] REG_STAT5 = 9'h125;

   localparam int CMD_LSB = 4;
   localparam int CMD_W = 3;
   localparam logic [CMD_W-1:0] CMD_TABLE_WRITE = 3'h4;
   localparam logic [CMD_W-1:0] CMD_TABLE_READ = 3'h5;
   localparam int BUSY_BIT = 15;
   localparam int RESULT_LSB = 12;
   localparam logic [2:0] RES_OK = 3'h0;
   localparam logic [2:0] RES_BAD_CMD = 3'h1;

   localparam logic [15:0] ETH_TYPE_IPV4 = 16'h0800;
   localparam logic [3:0] IP_VER4 = 4'h4;
   localparam logic [7:0] PROTO_IGMP = 8'h02;
   localparam logic [7:0] MSG_QUERY = 8'h11;
   localparam logic [7:0] MSG_REPORT_V1 = 8'h12;
   localparam logic [7:0] MSG_REPORT_V2 = 8'h16;
   localparam logic [7:0] MSG_LEAVE = 8'h17;
   localparam logic [31:0] ALL_HOSTS_IP = 32'hE0000001;
   localparam logic [31:0] CLASS_D_LO = 32'hE0000000;
   localparam logic [31:0] CLASS_D_HI = 32'hEFFFFFFF;
   localparam logic [31:0] RESERVED_LO = 32'hE0000001;
   localparam logic [31:0] RESERVED_HI = 32'hE00000FF;
   localparam logic [23:0] MAC_OUI = 24'h01005E;

   typedef struct packed {
      logic [15:0] ethType;
      logic [3:0] ipVersion;
      logic [7:0] ipProto;
      logic [31:0] dstIp;
      logic [7:0] msgType;
      logic [31:0] groupAddr;
      logic [PORT_ID_W-1:0] rxPort;
   } mmt_frame_type;

   typedef struct packed {
      logic isMulticast;
      logic isReserved;
      logic isGeneralQuery;
      logic isJoin;
      logic isLeave;
      logic [47:0] groupMac;
   } mmt_class_type;
endpackage

module mmt_table_mem
   import mmt_pkg::*;
#(
   parameter int DEPTH = ENTRY_COUNT,
   parameter int WIDTH = ENTRY_W
) (
   input wire logic clk,
   input wire logic writeEn,
   input wire logic [$clog2(DEPTH)-1:0] addr,
   input wire logic [WIDTH-1:0] writeData,
   output logic [WIDTH-1:0] readData
);
   logic [WIDTH-1:0] store [DEPTH];

   // refused at elaboration, before any logic is built
   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("mmt_table_mem: bad DEPTH or WIDTH");
   end

   // read-before-write: a read on a write cycle returns the old word
   always_ff @(posedge clk) begin
      if (writeEn) begin
         store[addr] <= writeData;
      end
      readData <= store[addr];
   end
endmodule // mmt_table_mem

`default_nettype wire

// ===== verif/mmt_membership_table_test.sv
// Purpose: self-checking bench for the multicast membership table
// Assumes: 40 MHz clock, inputs driven 1 ns after the rising edge
// Notes: table memory has no reset, so every entry is zeroed first
`default_nettype none

module mmt_membership_table_test
   import mmt_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic snoopEnable = 1'b0;
   logic frameValid = 1'b0;
   logic [REG_ADDR_W-1:0] regAddr = '0;
   logic [WORD_W-1:0] regWriteData = '0;
   logic [WORD_W-1:0] regReadData;
   logic regReadValid, frameReady, classValid, fwdValid, tableFull;
   logic [PORT_COUNT-1:0] staticPortMap = 6'h2A;
   logic [PORT_COUNT-1:0] fwdPortMap;
   mmt_frame_type frameHeader = '0;
   mmt_class_type classResult;
   int n_mismatch = 0;
   int check_count = 0;
   int fwdCount = 0;
   logic [15:0] rdv;
   mmt_entry_type ent;

   always #12.5 clk = ~clk;
   always @(posedge clk) if (fwdValid === 1'b1) fwdCount++;

   mmt_membership_table i_dut (.clk, .sys_rst, .regWrite, .regRead, .regAddr, .regWriteData,
      .regReadData, .regReadValid, .snoopEnable, .staticPortMap, .frameValid, .frameHeader,
      .frameReady, .classValid, .classResult, .fwdValid, .fwdPortMap, .tableFull);

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   // an idle edge after each strobe so no signal is set twice in a step
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      tick();
      regWrite = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [8:0] a);
      regAddr = a;
      regRead = 1'b1;
      tick();
      regRead = 1'b0;
      rdv = regReadData;
      tick();
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 20; i++) begin
         rd(REG_STAT5);
         if (rdv[15] === 1'b0) return;
      end
      n_mismatch++;
      complete_run();
   endtask

   task automatic cmd(input logic [2:0] c, input logic [4:0] idx, input mmt_entry_type e);
      logic [63:0] x;
      x = 64'(e);
      wait_idle();
      for (int k = 0; k < 4; k++) wr(REG_CTRL0 + 9'(k), x[16*k +: 16]);
      wr(REG_CTRL0 + 9'h004, {11'h000, idx});
      regAddr = REG_CTRL5;
      regWriteData = {9'h000, c, 4'h0};
      regWrite = 1'b1;
      tick();
      regWrite = 1'b0;
      regAddr = REG_STAT5;
      regRead = 1'b1;
      tick();
      regRead = 1'b0;
      chk("busy after command", 1'b1, regReadData[15]);
      tick();
      wait_idle();
   endtask

   task automatic rdent(input logic [4:0] idx);
      logic [63:0] x;
      cmd(CMD_TABLE_READ, idx, '0);
      for (int k = 0; k < 4; k++) begin
         rd(REG_STAT0 + 9'(k));
         x[16*k +: 16] = rdv;
      end
      ent = x[57:0];
      rd(REG_STAT0 + 9'h004);
      chk("read index", idx, rdv[4:0]);
      rd(REG_STAT5);
      chk("read status", 16'h0000, rdv);
   endtask

   // without a scan, no table update may follow within a scan time
   task automatic send(input logic [15:0] eth, input logic [31:0] dst, input logic [31:0] grp,
      input logic [7:0] msg, input logic [2:0] port, input bit scan);
      int n;
      for (n = 0; n < 100 && frameReady !== 1'b1; n++) tick();
      if (n == 100) begin
         n_mismatch++;
         complete_run();
      end
      frameHeader = '{eth, IP_VER4, PROTO_IGMP, dst, msg, grp, port};
      frameValid = 1'b1;
      tick();
      frameValid = 1'b0;
      chk("class valid", 1'b1, classValid);
      n = fwdCount;
      if (!scan) begin
         repeat (70) tick();
         chk("no table update", n, fwdCount);
         return;
      end
      for (n = 0; n < 80 && fwdValid !== 1'b1; n++) tick();
      if (n == 80) begin
         n_mismatch++;
         complete_run();
      end
   endtask

   task automatic classify();
      logic [31:0] dst[7] = '{32'hE6141414, 32'hDFFFFFFF, 32'hEFFFFFFF, 32'hF0000000,
         32'hE0000000, 32'hE0000001, 32'hE0000001};
      logic [31:0] grp[7] = '{32'hE6141414, 32'hE00000FF, 32'hE0000100, 32'hE0000001,
         32'hE20A0A0A, 32'h00000000, 32'h00000000};
      logic [7:0] msg[7] = '{8'h16, 8'h12, 8'h17, 8'h11, 8'h12, 8'h11, 8'h11};
      logic mc, rsv, gq, gd, jn;
      for (int i = 0; i < 7; i++) begin
         send(i == 6 ? 16'h86DD : 16'h0800, dst[i], grp[i], msg[i], 3'h3, 1'b0);
         mc = dst[i] >= 32'hE0000000 && dst[i] <= 32'hEFFFFFFF;
         rsv = grp[i] >= 32'hE0000001 && grp[i] <= 32'hE00000FF;
         gq = i != 6 && dst[i] == 32'hE0000001 && msg[i] == 8'h11 && grp[i] == '0;
         // reserved or non-group addresses never count as join or leave
         gd = i != 6 && grp[i][31:28] == 4'hE && !rsv;
         jn = gd && (msg[i] == 8'h12 || msg[i] == 8'h16);
         chk("class result", {mc, rsv, gq, jn,
            gd && msg[i] == 8'h17, 24'h01005E, 1'b0, grp[i][22:0]}, classResult);
      end
   endtask

   task automatic table_access();
      wr(REG_CTRL0 + 9'h004, 16'h001F);
      rd(REG_CTRL0 + 9'h004);
      chk("index word readback", 16'h001F, rdv);
      rd(9'h000);
      chk("unmapped read", 16'h0000, rdv);
      cmd(CMD_TABLE_WRITE, 5'h1F, {2'b11, 27'h0, 6'h2D, 23'h5A3C1E});
      rdent(5'h1F);
      chk("entry 31", {2'b11, 27'h0, 6'h2D, 23'h5A3C1E}, ent);
      rdent(5'h00);
      chk("entry 0", 58'h0, ent);
      cmd(3'h2, 5'h00, '0);
      rd(REG_STAT5);
      chk("unknown command", 16'h1000, rdv);
      cmd(CMD_TABLE_WRITE, 5'h1F, '0);
   endtask

   task automatic snoop();
      snoopEnable = 1'b1;
      send(16'h0800, 32'hE6141414, 32'hE6141414, 8'h16, 3'h2, 1'b1);
      chk("join map", 6'h04, fwdPortMap);
      send(16'h0800, 32'hE6141414, 32'hE6141414, 8'h12, 3'h5, 1'b1);
      chk("second join map", 6'h24, fwdPortMap);
      for (int i = 0; i < 32; i++) begin
         rdent(5'(i));
         if (ent.occupied === 1'b1) break;
      end
      chk("snooped entry", {2'b01, 27'h0, 6'h24, 23'h141414}, ent);
      send(16'h0800, 32'hE0000002, 32'hE6141414, 8'h17, 3'h2, 1'b1);
      chk("leave map", 6'h20, fwdPortMap);
      send(16'h0800, 32'hE0000002, 32'hE6141414, 8'h17, 3'h5, 1'b1);
      chk("last leave map", 6'h00, fwdPortMap);
      send(16'h0800, 32'hE0000005, 32'hE0000005, 8'h16, 3'h1, 1'b0);
      for (int i = 0; i < 32; i++) begin
         send(16'h0800, 32'hE1000000 + 32'(i), 32'hE1000000 + 32'(i), 8'h16, 3'(i % 6), 1'b1);
         chk("not yet full", 1'b0, tableFull);
      end
      send(16'h0800, 32'hE1000040, 32'hE1000040, 8'h16, 3'h1, 1'b1);
      chk("full flag", 1'b1, tableFull);
      chk("static map", 6'h2A, fwdPortMap);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk("ready in reset", 1'b0, frameReady);
      sys_rst = 1'b0;
      tick();
      chk("ready after reset", 1'b1, frameReady);
      for (int i = 0; i < 32; i++) cmd(CMD_TABLE_WRITE, 5'(i), '0);
      table_access();
      classify();
      snoop();
      complete_run();
   end
endmodule // mmt_membership_table_test

bind mmt_membership_table mmt_table_monitor #(.PORTS(PORTS)) i_mon (.clk, .sys_rst, .regRead,
   .regReadValid, .snoopEnable, .staticPortMap, .frameValid, .frameHeader, .frameReady,
   .classValid, .classResult, .fwdValid, .fwdPortMap, .tableFull);

`default_nettype wire

// ===== verif/mmt_table_monitor.sv
// Purpose: concurrent checks on the membership table ports
// Assumes: bound to mmt_membership_table, one clock domain
// Notes: busy timing is judged by the bench through register reads
`default_nettype none

module mmt_table_monitor
   import mmt_pkg::*;
#(
   parameter int PORTS = PORT_COUNT
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regRead,
   input wire logic regReadValid,
   input wire logic snoopEnable,
   input wire logic [PORTS-1:0] staticPortMap,
   input wire logic frameValid,
   input wire mmt_frame_type frameHeader,
   input wire logic frameReady,
   input wire logic classValid,
   input wire mmt_class_type classResult,
   input wire logic fwdValid,
   input wire logic [PORTS-1:0] fwdPortMap,
   input wire logic tableFull
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic take = frameValid && frameReady;
   mmt_frame_type lastHdr;
   logic [PORT_ID_W-1:0] takenPort;
   logic [31:0] takenGrp;
   // header of the frame taken last, judged when the class result shows
   always_ff @(posedge clk) begin
      lastHdr <= frameHeader;
      if (take) begin
         takenPort <= frameHeader.rxPort;
         takenGrp <= frameHeader.groupAddr;
      end
   end
   chk_read_answer: assert property (regReadValid == $past(regRead))
      else $error("read valid not one cycle after read strobe");
   chk_class_pulse: assert property (classValid == $past(take))
      else $error("class valid not one cycle after frame take");
   chk_mac_form: assert property (classValid |->
      classResult.groupMac == {24'h01005E, 1'b0, lastHdr.groupAddr[22:0]})
      else $error("group mac not formed from group address");
   chk_class_d: assert property (classValid |-> classResult.isMulticast ==
      (lastHdr.dstIp >= 32'hE0000000 && lastHdr.dstIp <= 32'hEFFFFFFF))
      else $error("multicast flag wrong");
   chk_reserved_grp: assert property (classValid |-> classResult.isReserved ==
      (lastHdr.groupAddr >= 32'hE0000001 && lastHdr.groupAddr <= 32'hE00000FF))
      else $error("reserved flag wrong");
   chk_general_query: assert property (classValid |-> classResult.isGeneralQuery ==
      (lastHdr.ethType == 16'h0800 && lastHdr.ipVersion == 4'h4 && lastHdr.ipProto == 8'h02
      && lastHdr.dstIp == 32'hE0000001 && lastHdr.msgType == 8'h11 && lastHdr.groupAddr == '0))
      else $error("general query flag wrong");
   chk_snoop_timing: assert property (fwdValid |->
      $past(classValid, 65) && $past(snoopEnable, 66))
      else $error("table update without enabled snoop take");
   chk_update_group: assert property (fwdValid |->
      takenGrp[31:28] == 4'hE && !classResult.isReserved)
      else $error("table update for a non-member group");
   chk_join_map: assert property (fwdValid && classResult.isJoin && !tableFull |->
      fwdPortMap[takenPort])
      else $error("joining port missing from map");
   chk_leave_map: assert property (fwdValid && classResult.isLeave |->
      !fwdPortMap[takenPort])
      else $error("leaving port still in map");
   chk_full_map: assert property (fwdValid && tableFull && classResult.isJoin |->
      fwdPortMap == staticPortMap)
      else $error("full table did not use static map");
endmodule // mmt_table_monitor

`default_nettype wire
